// [rtl/dcs_pkg.sv]
// package for the device-side clock change, dll switch and write leveling block
`default_nettype none
package dcs_pkg;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_MRS,
        OP_SRE,
        OP_SRX,
        OP_PDE,
        OP_PDX,
        OP_ZQCL
    } dcs_op_t;

    typedef struct packed {
        dcs_op_t     op;
        logic [2:0]  mr;
        logic [15:0] addr;
    } dcs_cmd_t;

    typedef struct packed {
        logic ck;
        logic cke;
        logic odt;
        logic upper_lane_strobe_pair;
        logic lower_lane_strobe_pair;
    } dcs_pins_t;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_SELF_REFRESH,
        ST_POWER_DOWN
    } dcs_state_t;

    localparam int          PIN_COUNT         = 5;
    localparam logic [2:0]  MR_SEL_0          = 3'h0;
    localparam logic [2:0]  MR_SEL_1          = 3'h1;
    localparam int          MR0_DLL_RESET_BIT = 8;
    localparam int          MR1_DLL_OFF_BIT   = 0;
    localparam int          MR1_LEVEL_BIT     = 7;
    localparam int          MR1_QOFF_BIT      = 12;
    localparam int          MR1_RTT_BIT_A     = 2;
    localparam int          MR1_RTT_BIT_B     = 6;
    localparam int          MR1_RTT_BIT_C     = 9;
    localparam logic [15:0] MR1_RESET         = 16'h0000;

    localparam int DQ_WIDTH   = 16;
    localparam int LANE_WIDTH = 8;
    localparam int LANES      = 2;

    // timing in picoseconds, dll lock in clock cycles; counts round up as least times
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_CKSRE_PS    = 10000;
    localparam int CKSRE_CYC     = (T_CKSRE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TDLLK_NCK     = 512;

endpackage : dcs_pkg
`default_nettype wire

// [rtl/dcs_sync.sv]
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dcs_sync
    import dcs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,   // core clock
    input  wire logic             reset_in, // synchronous reset, active high
    input  wire logic             ce_in,    // clock enable
    input  wire logic [WIDTH-1:0] async_in, // raw pin levels
    output logic      [WIDTH-1:0] sync_out  // synchronised levels
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // first stage feeds only the second stage
    always_comb
    begin
        next_meta = async_in;
        next_sync = meta;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else if (ce_in)
        begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end

endmodule : dcs_sync
`default_nettype wire

// [rtl/dcs_device.sv]
// device-side dll switch, clock change tracking and write leveling feedback
`timescale 1ns/1ps
`default_nettype none
module dcs_device
    import dcs_pkg::*;
#(
    parameter int TDLLK       = TDLLK_NCK, // link clock edges to dll lock
    parameter bit FEEDBACK_ALL = 1'b0      // all lane bits carry feedback
) (
    input  wire logic                clk_in,             // core clock, 200 MHz
    input  wire logic                reset_in,           // synchronous reset, active high
    input  wire logic                ce_in,              // clock enable, freezes state
    input  wire dcs_pins_t           pins_in,            // raw controller pins
    input  wire logic                cmd_valid_in,       // decoded command valid
    input  wire dcs_cmd_t            cmd_in,             // decoded command
    output logic [DQ_WIDTH-1:0]      dq_out,             // data pin drive value
    output logic [DQ_WIDTH-1:0]      dq_oe_out,          // data pin output enable
    output logic [LANES-1:0]         strobe_term_out,    // strobe termination on, per lane
    output logic                     rtt_on_out,         // data termination on
    output dcs_state_t               state_out,          // power state
    output logic                     clock_ignored_out,  // input clock is don't care
    output logic                     dll_enabled_out,    // dll switched on
    output logic                     dll_locked_out,     // dll lock time elapsed
    output logic                     leveling_out,       // write leveling mode
    output logic                     seq_error_out       // sticky pin misuse flag
);

    localparam int LOCK_W  = $clog2(TDLLK + 1);
    localparam int ENTRY_W = $clog2(CKSRE_CYC + 1);

    function automatic logic is_mrs(input dcs_cmd_t c, input logic [2:0] sel);
        is_mrs = (c.op == OP_MRS) && (c.mr == sel);
    endfunction : is_mrs

    function automatic logic [LANE_WIDTH-1:0] lane_bus(input logic fb, input logic all);
        lane_bus = all ? {LANE_WIDTH{fb}} : {{(LANE_WIDTH-1){1'b0}}, fb};
    endfunction : lane_bus

    dcs_pins_t pins_s;

    dcs_sync #(
        .WIDTH (PIN_COUNT)
    ) u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .ce_in    (ce_in),
        .async_in (pins_in),
        .sync_out (pins_s)
    );

    // power state, dll and termination
    dcs_state_t          state,         next_state;
    logic [ENTRY_W-1:0]  entry_cnt,     next_entry_cnt;
    logic                clock_ignored, next_clock_ignored;
    logic                dll_off,       next_dll_off;
    logic                level,         next_level;
    logic                qoff,          next_qoff;
    logic                rtt_nom,       next_rtt_nom;
    logic                rtt_at_entry,  next_rtt_at_entry;
    logic [LOCK_W-1:0]   lock_cnt,      next_lock_cnt;
    logic                locked,        next_locked;
    logic                relock,        next_relock;
    logic                ck_prev,       next_ck_prev;
    logic                seq_error,     next_seq_error;
    logic                rtt_on,        next_rtt_on;
    logic                ck_rise;

    assign ck_rise = pins_s.ck & ~ck_prev;

    always_comb
    begin
        next_state         = state;
        next_entry_cnt     = entry_cnt;
        next_clock_ignored = clock_ignored;
        next_dll_off       = dll_off;
        next_level         = level;
        next_qoff          = qoff;
        next_rtt_nom       = rtt_nom;
        next_rtt_at_entry  = rtt_at_entry;
        next_lock_cnt      = lock_cnt;
        next_locked        = locked;
        next_relock        = relock;
        next_ck_prev       = pins_s.ck;
        next_seq_error     = seq_error;

        // lock time counts clock edges only while the clock is followed
        if (relock && ck_rise && !clock_ignored)
        begin
            if (lock_cnt == LOCK_W'(TDLLK - 1))
            begin
                next_relock = 1'b0;
                next_locked = 1'b1;
            end
            else
            begin
                next_lock_cnt = lock_cnt + LOCK_W'(1);
            end
        end

        // after the entry interval the clock may stop or change
        if (state != ST_ACTIVE && !clock_ignored)
        begin
            if (entry_cnt == ENTRY_W'(CKSRE_CYC - 1))
                next_clock_ignored = 1'b1;
            else
                next_entry_cnt = entry_cnt + ENTRY_W'(1);
        end

        if (cmd_valid_in)
        begin
            case (cmd_in.op)
                OP_SRE:
                begin
                    if (state == ST_ACTIVE)
                    begin
                        next_state        = ST_SELF_REFRESH;
                        next_entry_cnt    = '0;
                        next_rtt_at_entry = rtt_nom;
                    end
                end
                OP_PDE:
                begin
                    if (state == ST_ACTIVE)
                    begin
                        next_state        = ST_POWER_DOWN;
                        next_entry_cnt    = '0;
                        next_rtt_at_entry = rtt_nom;
                    end
                end
                OP_SRX:
                begin
                    if (state == ST_SELF_REFRESH)
                    begin
                        next_state         = ST_ACTIVE;
                        next_clock_ignored = 1'b0;
                    end
                end
                OP_PDX:
                begin
                    if (state == ST_POWER_DOWN)
                    begin
                        next_state         = ST_ACTIVE;
                        next_clock_ignored = 1'b0;
                    end
                end
                OP_MRS:
                begin
                    if (is_mrs(cmd_in, MR_SEL_1))
                    begin
                        next_dll_off = cmd_in.addr[MR1_DLL_OFF_BIT];
                        next_level   = cmd_in.addr[MR1_LEVEL_BIT];
                        next_qoff    = cmd_in.addr[MR1_QOFF_BIT];
                        next_rtt_nom = cmd_in.addr[MR1_RTT_BIT_A]
                                     | cmd_in.addr[MR1_RTT_BIT_B]
                                     | cmd_in.addr[MR1_RTT_BIT_C];
                        if (cmd_in.addr[MR1_DLL_OFF_BIT])
                        begin
                            next_locked = 1'b0;
                            next_relock = 1'b0;
                        end
                    end
                    else if (is_mrs(cmd_in, MR_SEL_0) && cmd_in.addr[MR0_DLL_RESET_BIT]
                             && !dll_off)
                    begin
                        next_relock   = 1'b1;
                        next_locked   = 1'b0;
                        next_lock_cnt = '0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // misuse flags: the device relies on the controller for these levels
        if (relock && state == ST_ACTIVE)
        begin
            if (!pins_s.cke)
                next_seq_error = 1'b1;
            if (pins_s.odt && rtt_at_entry)
                next_seq_error = 1'b1;
        end
        if (state == ST_POWER_DOWN && rtt_at_entry && pins_s.odt)
            next_seq_error = 1'b1;

        // in power-down or self-refresh termination stays off regardless of odt
        next_rtt_on = pins_s.odt & rtt_nom & ~level & (state == ST_ACTIVE);
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state         <= ST_ACTIVE;
            entry_cnt     <= '0;
            clock_ignored <= 1'b0;
            dll_off       <= MR1_RESET[MR1_DLL_OFF_BIT];
            level         <= MR1_RESET[MR1_LEVEL_BIT];
            qoff          <= MR1_RESET[MR1_QOFF_BIT];
            rtt_nom       <= 1'b0;
            rtt_at_entry  <= 1'b0;
            lock_cnt      <= '0;
            locked        <= 1'b0;
            relock        <= 1'b0;
            ck_prev       <= 1'b0;
            seq_error     <= 1'b0;
            rtt_on        <= 1'b0;
        end
        else if (ce_in)
        begin
            state         <= next_state;
            entry_cnt     <= next_entry_cnt;
            clock_ignored <= next_clock_ignored;
            dll_off       <= next_dll_off;
            level         <= next_level;
            qoff          <= next_qoff;
            rtt_nom       <= next_rtt_nom;
            rtt_at_entry  <= next_rtt_at_entry;
            lock_cnt      <= next_lock_cnt;
            locked        <= next_locked;
            relock        <= next_relock;
            ck_prev       <= next_ck_prev;
            seq_error     <= next_seq_error;
            rtt_on        <= next_rtt_on;
        end
    end

    // write leveling, one engine per byte lane
    logic [LANES-1:0] strobe_s;

    assign strobe_s = {pins_s.upper_lane_strobe_pair, pins_s.lower_lane_strobe_pair};

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            logic                  dqs_prev, next_dqs_prev;
            logic                  fb,       next_fb;
            logic                  sampled,  next_sampled;
            logic [LANE_WIDTH-1:0] dq,       next_dq;
            logic [LANE_WIDTH-1:0] oe,       next_oe;
            logic                  term,     next_term;

            always_comb
            begin
                next_dqs_prev = strobe_s[g];
                next_fb       = fb;
                next_sampled  = sampled;
                // each lane samples the clock on its own strobe
                if (level && strobe_s[g] && !dqs_prev)
                begin
                    next_fb      = pins_s.ck;
                    next_sampled = 1'b1;
                end
                if (!level)
                begin
                    next_fb      = 1'b0;
                    next_sampled = 1'b0;
                end
                // before the first sample the bus value is undefined, so low is fine
                next_dq   = lane_bus(next_fb, FEEDBACK_ALL & ~next_sampled)
                          | lane_bus(next_fb, FEEDBACK_ALL);
                next_oe   = {LANE_WIDTH{level & ~qoff}};
                next_term = level & pins_s.odt;
            end

            always_ff @(posedge clk_in)
            begin
                if (reset_in)
                begin
                    dqs_prev <= 1'b0;
                    fb       <= 1'b0;
                    sampled  <= 1'b0;
                    dq       <= '0;
                    oe       <= '0;
                    term     <= 1'b0;
                end
                else if (ce_in)
                begin
                    dqs_prev <= next_dqs_prev;
                    fb       <= next_fb;
                    sampled  <= next_sampled;
                    dq       <= next_dq;
                    oe       <= next_oe;
                    term     <= next_term;
                end
            end

            assign dq_out[g*LANE_WIDTH +: LANE_WIDTH]    = dq;
            assign dq_oe_out[g*LANE_WIDTH +: LANE_WIDTH] = oe;
            assign strobe_term_out[g]                    = term;
        end
    endgenerate

    assign rtt_on_out        = rtt_on;
    assign state_out         = state;
    assign clock_ignored_out = clock_ignored;
    assign dll_enabled_out   = ~dll_off;
    assign dll_locked_out    = locked;
    assign leveling_out      = level;
    assign seq_error_out     = seq_error;

endmodule : dcs_device
`default_nettype wire

// [verification/dcs_device_chk.sv]
// checker for the device-side dll switch, clock change and leveling block
`timescale 1ns/1ps
`default_nettype none
module dcs_device_chk
    import dcs_pkg::*;
#(
    parameter int TDLLK        = 8,
    parameter bit FEEDBACK_ALL = 1'b0
) (
    input wire logic                clk_in,            // core clock
    input wire logic                reset_in,          // sync reset
    input wire logic                ce_in,             // clock enable
    input wire dcs_pins_t           pins_in,           // raw pins
    input wire logic                cmd_valid_in,      // command valid
    input wire dcs_cmd_t            cmd_in,            // command
    input wire logic [DQ_WIDTH-1:0] dq_out,            // data drive
    input wire logic [DQ_WIDTH-1:0] dq_oe_out,         // data enable
    input wire logic [LANES-1:0]    strobe_term_out,   // strobe term
    input wire logic                rtt_on_out,        // data term
    input wire dcs_state_t          state_out,         // power state
    input wire logic                clock_ignored_out, // clock ignored
    input wire logic                dll_enabled_out,   // dll on
    input wire logic                dll_locked_out,    // dll locked
    input wire logic                leveling_out,      // leveling
    input wire logic                seq_error_out      // misuse flag
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire logic mrs1  = cmd_valid_in && ce_in && cmd_in.op == OP_MRS && cmd_in.mr == MR_SEL_1;
    wire logic entry = cmd_valid_in && ce_in && state_out == ST_ACTIVE
                       && cmd_in.op inside {OP_SRE, OP_PDE};
    sequence s_ignore_wait;
        !clock_ignored_out [*2] ##1 clock_ignored_out;
    endsequence
    sequence s_low_edge;
        leveling_out && $rose(pins_in.lower_lane_strobe_pair);
    endsequence
    sequence s_up_edge;
        leveling_out && $rose(pins_in.upper_lane_strobe_pair);
    endsequence
    chk_level_mode: assert property (
        mrs1 |=> leveling_out == $past(cmd_in.addr[MR1_LEVEL_BIT]))
        else $error("leveling mode does not follow mode write");
    chk_dll_switch: assert property (
        mrs1 |=> dll_enabled_out == !$past(cmd_in.addr[MR1_DLL_OFF_BIT]))
        else $error("dll enable does not follow mode write");
    chk_clock_ignore: assert property (
        entry |=> s_ignore_wait)
        else $error("clock ignore not raised after entry interval");
    chk_pd_rtt_off: assert property (
        state_out == ST_POWER_DOWN && $past(state_out) == ST_POWER_DOWN |-> !rtt_on_out)
        else $error("data termination on in power-down");
    chk_strobe_term: assert property (
        $rose(strobe_term_out[0]) |-> $past(leveling_out) && $past(pins_in.odt, 3))
        else $error("strobe termination without leveling and odt");
    chk_level_rtt_off: assert property (
        leveling_out && $past(leveling_out) |-> !rtt_on_out)
        else $error("data termination on while leveling");
    chk_lower_sample: assert property (
        s_low_edge |-> ##4 dq_out[0] == $past(pins_in.ck, 4))
        else $error("lower lane feedback wrong");
    chk_upper_sample: assert property (
        s_up_edge |-> ##4 dq_out[LANE_WIDTH] == $past(pins_in.ck, 4))
        else $error("upper lane feedback wrong");
    chk_spare_low: assert property (
        leveling_out && !FEEDBACK_ALL |-> (dq_out & 16'hfefe) == 16'h0000)
        else $error("non feedback data bit driven high");
endmodule : dcs_device_chk
bind dcs_device dcs_device_chk #(
    .TDLLK       (TDLLK),
    .FEEDBACK_ALL(FEEDBACK_ALL)
) chk_u (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .pins_in(pins_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
    .strobe_term_out(strobe_term_out), .rtt_on_out(rtt_on_out), .state_out(state_out),
    .clock_ignored_out(clock_ignored_out), .dll_enabled_out(dll_enabled_out),
    .dll_locked_out(dll_locked_out), .leveling_out(leveling_out),
    .seq_error_out(seq_error_out)
);
`default_nettype wire

// [verification/dcs_ctrl_model.sv]
// controller-side model: link clock, enable, termination control and strobes
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_model
    import dcs_pkg::*;
(
    input  wire logic       run_in,  // link clock runs, else stands still
    input  wire logic [7:0] half_in, // link clock half period in ns
    input  wire logic       cke_in,  // clock enable level
    input  wire logic       odt_in,  // termination control level
    output var  dcs_pins_t  pins_out // pins toward the device
);
    logic ck        = 1'b0;
    logic lo_strobe = 1'b0;
    logic up_strobe = 1'b0;
    assign pins_out = '{ck, cke_in, odt_in, up_strobe, lo_strobe};
    // odd start offset keeps link edges away from core clock edges
    initial
    begin
        #1.3;
        forever
        begin
            #(half_in);
            if (run_in)
                ck = ~ck;
        end
    end
    // one rise per lane, each at its own delay after a link clock rise
    task automatic pulse(input int lo_dly, input int up_dly);
        @(posedge ck);
        fork
            begin
                #(lo_dly);
                lo_strobe = 1'b1;
                #40;
                lo_strobe = 1'b0;
            end
            begin
                #(up_dly);
                up_strobe = 1'b1;
                #40;
                up_strobe = 1'b0;
            end
        join
    endtask : pulse
endmodule : dcs_ctrl_model
`default_nettype wire

// [verification/tb_dcs_device.sv]
// self-checking bench for the device-side dll switch and leveling block
`timescale 1ns/1ps
`default_nettype none
module tb_dcs_device import dcs_pkg::*;;
    typedef struct packed {
        dcs_op_t     op;
        logic [2:0]  mr;
        logic [15:0] a;
        dcs_state_t  st;
        logic        dll;
        logic        lev;
    } dcs_row_t;
    logic                clk_in = 1'b0, reset_in = 1'b1, cmd_valid_in = 1'b0;
    logic                ck_run = 1'b1, cke = 1'b1, odt = 1'b0, fb_prev, ce = 1'b1;
    logic [7:0]          half = 8'h50;
    dcs_cmd_t            cmd_in = '0;
    dcs_pins_t           pins;
    logic [DQ_WIDTH-1:0] dq_out, dq_oe_out;
    logic [LANES-1:0]    strobe_term_out;
    logic                rtt_on_out, clock_ignored_out, dll_enabled_out;
    logic                dll_locked_out, leveling_out, seq_error_out;
    dcs_state_t          state_out;
    int                  bad_count = 0, check_count = 0, cycles = 0, n, lock_dly;
    dcs_row_t rows [14] = '{
        '{OP_MRS, MR_SEL_1, 16'h0001, ST_ACTIVE, 1'b0, 1'b0},
        '{OP_MRS, MR_SEL_1, 16'h0000, ST_ACTIVE, 1'b1, 1'b0},
        '{OP_SRE, 3'h0, 16'h0000, ST_SELF_REFRESH, 1'b1, 1'b0},
        '{OP_SRE, 3'h0, 16'h0000, ST_SELF_REFRESH, 1'b1, 1'b0},
        '{OP_PDX, 3'h0, 16'h0000, ST_SELF_REFRESH, 1'b1, 1'b0},
        '{OP_SRX, 3'h0, 16'h0000, ST_ACTIVE, 1'b1, 1'b0},
        '{OP_PDE, 3'h0, 16'h0000, ST_POWER_DOWN, 1'b1, 1'b0},
        '{OP_SRX, 3'h0, 16'h0000, ST_POWER_DOWN, 1'b1, 1'b0},
        '{OP_PDX, 3'h0, 16'h0000, ST_ACTIVE, 1'b1, 1'b0},
        '{OP_SRX, 3'h0, 16'h0000, ST_ACTIVE, 1'b1, 1'b0},
        '{OP_ZQCL, 3'h0, 16'h0000, ST_ACTIVE, 1'b1, 1'b0},
        '{OP_MRS, MR_SEL_1, 16'h0080, ST_ACTIVE, 1'b1, 1'b1},
        '{OP_MRS, 3'h2, 16'h0000, ST_ACTIVE, 1'b1, 1'b1},
        '{OP_MRS, MR_SEL_1, 16'h0000, ST_ACTIVE, 1'b1, 1'b0}};
    dcs_ctrl_model ctl_u (.run_in(ck_run), .half_in(half), .cke_in(cke), .odt_in(odt),
        .pins_out(pins));
    dcs_device #(.TDLLK(8), .FEEDBACK_ALL(1'b0)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
        .ce_in(ce), .pins_in(pins), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .dq_out(dq_out), .dq_oe_out(dq_oe_out), .strobe_term_out(strobe_term_out),
        .rtt_on_out(rtt_on_out), .state_out(state_out), .clock_ignored_out(clock_ignored_out),
        .dll_enabled_out(dll_enabled_out), .dll_locked_out(dll_locked_out),
        .leveling_out(leveling_out), .seq_error_out(seq_error_out));
    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic summarize();
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_cyc(input int k);
        repeat (k) @(negedge clk_in);
    endtask : wait_cyc
    // returns one cycle after the answer edge, so outputs are settled
    task automatic send(input dcs_op_t op, input logic [2:0] mr, input logic [15:0] a);
        @(negedge clk_in);
        cmd_in = '{op, mr, a};
        cmd_valid_in = 1'b1;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
        @(negedge clk_in);
    endtask : send
    // window allows for the unknown link clock phase at the dll reset
    task automatic lock_chk(input int lo, input int hi);
        check({dll_enabled_out, dll_locked_out}, 2'b10);
        n = 0;
        while (dll_locked_out !== 1'b1 && n < 400)
        begin
            @(negedge clk_in);
            n++;
        end
        check({n >= lo && n <= hi, seq_error_out}, 2'b10);
    endtask : lock_chk
    initial
    begin
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'b0;
        check({state_out, dll_enabled_out, dll_locked_out, leveling_out, seq_error_out},
              {ST_ACTIVE, 1'b1, 3'h0});
        check({rtt_on_out, strobe_term_out, clock_ignored_out, dq_out, dq_oe_out}, 24'h0);
        wait_cyc(2);
        foreach (rows[i])
        begin
            send(rows[i].op, rows[i].mr, rows[i].a);
            check({state_out, dll_enabled_out, leveling_out},
                  {rows[i].st, rows[i].dll, rows[i].lev});
        end
        send(OP_MRS, MR_SEL_1, 16'h0005);
        send(OP_SRE, 3'h0, 16'h0000);
        wait_cyc(4);
        check(clock_ignored_out, 1'b1);
        ck_run = 1'b0;
        half = 8'h28;
        wait_cyc(10);
        ck_run = 1'b1;
        wait_cyc(20);
        send(OP_SRX, 3'h0, 16'h0000);
        check({state_out, clock_ignored_out}, {ST_ACTIVE, 1'b0});
        send(OP_MRS, MR_SEL_1, 16'h0004);
        send(OP_MRS, MR_SEL_0, 16'h0100);
        lock_chk(100, 140);
        odt = 1'b1;
        wait_cyc(6);
        check(rtt_on_out, 1'b1);
        odt = 1'b0;
        cke = 1'b0;
        wait_cyc(6);
        send(OP_PDE, 3'h0, 16'h0000);
        wait_cyc(4);
        check({state_out, rtt_on_out, clock_ignored_out}, {ST_POWER_DOWN, 2'b01});
        ck_run = 1'b0;
        half = 8'h50;
        wait_cyc(10);
        ck_run = 1'b1;
        wait_cyc(20);
        cke = 1'b1;
        send(OP_PDX, 3'h0, 16'h0000);
        send(OP_MRS, MR_SEL_0, 16'h0100);
        lock_chk(215, 270);
        odt = 1'b1;
        send(OP_MRS, MR_SEL_1, 16'h0084);
        wait_cyc(6);
        check({strobe_term_out, rtt_on_out, dq_oe_out}, {3'b110, 16'hffff});
        fb_prev = 1'b1;
        lock_dly = 0;
        for (int d = 20; d <= 180; d += 40)
        begin
            ctl_u.pulse(d, d + 80);
            wait_cyc(6);
            check(dq_out, {7'h0, ((d + 80) % 160) < 80, 7'h0, (d % 160) < 80});
            if (!fb_prev && dq_out[0])
                lock_dly = d;
            fb_prev = dq_out[0];
        end
        check(lock_dly[15:0], 16'h00b4);
        send(OP_MRS, MR_SEL_1, 16'h1084);
        wait_cyc(2);
        check({leveling_out, dq_oe_out}, {1'b1, 16'h0000});
        odt = 1'b0;
        send(OP_MRS, MR_SEL_1, 16'h0004);
        wait_cyc(2);
        check({leveling_out, strobe_term_out, dq_oe_out}, 24'h0);
        cke = 1'b0;
        send(OP_PDE, 3'h0, 16'h0000);
        odt = 1'b1;
        wait_cyc(6);
        check({rtt_on_out, seq_error_out}, 2'b01);
        // a frozen block must not take the exit command
        ce = 1'b0;
        send(OP_PDX, 3'h0, 16'h0000);
        check(state_out, ST_POWER_DOWN);
        ce = 1'b1;
        reset_in = 1'b1;
        wait_cyc(2);
        reset_in = 1'b0;
        check({state_out, dll_locked_out, seq_error_out}, {ST_ACTIVE, 2'b00});
        wait_cyc(2);
        send(OP_MRS, MR_SEL_0, 16'h0100);
        wait_cyc(2);
        check(seq_error_out, 1'b1);
        summarize();
    end
endmodule : tb_dcs_device
`default_nettype wire
